// ### shared/ciopb_pkg.sv
// Shared constants for the configurable I/O port bank
package ciopb_pkg;
    // ---------------------------------------------------------------
    // Geometry
    // ---------------------------------------------------------------
    localparam int         NUM_PORTS = 7;
    localparam logic [2:0] PORT_A    = 3'h0;
    localparam logic [2:0] PORT_B    = 3'h1;
    localparam logic [2:0] PORT_C    = 3'h2;
    localparam logic [2:0] PORT_D    = 3'h3;
    localparam logic [2:0] PORT_E    = 3'h4;
    localparam logic [2:0] PORT_F    = 3'h5;
    localparam logic [2:0] PORT_G    = 3'h6;
    localparam logic [2:0] PORT_MISC = 3'h7;
    // ---------------------------------------------------------------
    // Register select, offset = {port, select}
    // ---------------------------------------------------------------
    localparam logic [2:0] REG_INPUT    = 3'h0;
    localparam logic [2:0] REG_OUTPUT   = 3'h1;
    localparam logic [2:0] REG_DIR      = 3'h2;
    localparam logic [2:0] REG_DRIVE    = 3'h3;
    localparam logic [2:0] REG_MODE     = 3'h4;
    localparam logic [2:0] REG_CELLS    = 3'h5;
    localparam logic [2:0] REG_MASK     = 3'h6;
    localparam logic [2:0] REG_MAP_MODE = 3'h0;
    localparam int         PERIPH_EN_BIT = 7;
    // ---------------------------------------------------------------
    // Reset values and per-port features (bit p = port p)
    // ---------------------------------------------------------------
    localparam logic [7:0]  CFG_RESET    = 8'h00;
    localparam logic [15:0] CELL_RESET   = 16'h0000;
    localparam logic [7:0]  PORT_D_MASK  = 8'h0f;
    localparam logic [6:0]  HAS_OE_TERM  = 7'h27;
    localparam logic [6:0]  HAS_DRIVE    = 7'h5b;
    localparam logic [6:0]  HAS_ADDR_OUT = 7'h70;
    localparam logic [15:0] CELL_LANE_A  = 16'h00ff;
    localparam logic [15:0] CELL_LANE_B  = 16'hff00;
endpackage : ciopb_pkg

// ### shared/ciopb_port_if.sv
// Register carrier between the bank decoder and one port
`timescale 1ns/1ps
`default_nettype none
interface ciopb_port_if;
    logic       wr;
    logic [2:0] sel;
    logic [7:0] wdata;
    logic [7:0] dir;
    logic [7:0] drive;
    logic [7:0] mode;
    logic [7:0] dout;
    logic [7:0] din;
    modport bank (output wr, sel, wdata, input dir, drive, mode, dout, din);
    modport port (input wr, sel, wdata, output dir, drive, mode, dout, din);
endinterface : ciopb_port_if
`default_nettype wire

// ### hdl/ciopb_port.sv
// One port: configuration registers, input sampling, pin drivers
`timescale 1ns/1ps
`default_nettype none
module ciopb_port
    import ciopb_pkg::*;
#(
    parameter logic [7:0] IMPL_MASK = 8'hff,
    parameter bit         HAS_OE    = 1'b0,
    parameter bit         HAS_OD    = 1'b0,
    parameter bit         HAS_ADDR  = 1'b0
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    ciopb_port_if.port      cfg,
    input  wire logic [7:0] pin_in,
    input  wire logic [7:0] oe_term,
    input  wire logic [7:0] addr_bits,
    input  wire logic [7:0] release_en,
    input  wire logic [7:0] force_en,
    input  wire logic [7:0] force_val,
    output logic      [7:0] pin_out,
    output logic      [7:0] pin_oe
);
    logic [7:0] sync_a;
    logic [7:0] io_en;
    logic [7:0] addr_sel;
    logic [7:0] drv_en;
    logic [7:0] drv_val;
    logic [7:0] od;

    if (IMPL_MASK == 8'h00) begin : g_bad
        $error("ciopb_port: a port needs at least one pin");
    end

    // ---------------------------------------------------------------
    // Configuration registers
    // ---------------------------------------------------------------
    // Missing registers stay zero so they read back as zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg.dir   <= CFG_RESET;
            cfg.drive <= CFG_RESET;
            cfg.mode  <= CFG_RESET;
            cfg.dout  <= CFG_RESET;
        end else if (cfg.wr) begin
            case (cfg.sel)
                REG_DIR:    cfg.dir   <= cfg.wdata & IMPL_MASK;
                REG_DRIVE:  cfg.drive <= HAS_OD ? (cfg.wdata & IMPL_MASK) : CFG_RESET;
                REG_MODE:   cfg.mode  <= HAS_ADDR ? cfg.wdata : CFG_RESET;
                REG_OUTPUT: cfg.dout  <= cfg.wdata & IMPL_MASK;
                default: ;
            endcase
        end
    end

    // Pins are asynchronous, so two stages before anyone reads them
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync_a  <= CFG_RESET;
            cfg.din <= CFG_RESET;
        end else begin
            sync_a  <= pin_in;
            cfg.din <= sync_a & IMPL_MASK;
        end
    end

    // ---------------------------------------------------------------
    // Pin drive
    // ---------------------------------------------------------------
    // Overrides from the bank win over the port's own function
    always_comb begin
        io_en    = cfg.dir | (HAS_OE ? oe_term : 8'h00);
        addr_sel = HAS_ADDR ? cfg.mode : 8'h00;
        drv_val  = (addr_sel & addr_bits) | (~addr_sel & cfg.dout);
        drv_en   = (addr_sel & (cfg.dir | oe_term)) | (~addr_sel & io_en);
        drv_en   = drv_en & ~release_en;
        drv_val  = (force_en & force_val) | (~force_en & drv_val);
        drv_en   = (drv_en | force_en) & IMPL_MASK;
        od       = HAS_OD ? cfg.drive : 8'h00;
    end

    // Open drain only ever pulls low; a high is left to the pull-up
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_out <= CFG_RESET;
            pin_oe  <= CFG_RESET;
        end else begin
            pin_out <= drv_val & ~od & IMPL_MASK;
            pin_oe  <= drv_en & ~(od & drv_val);
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    port_dir_a: assert property (@(posedge clk_sys) disable iff (rst)
        (cfg.wr && cfg.sel == REG_DIR && force_en == 8'h00 && release_en == 8'h00
         && oe_term == 8'h00 && cfg.mode == 8'h00 && cfg.drive == 8'h00)
        ##1 (force_en == 8'h00 && release_en == 8'h00 && oe_term == 8'h00)
        |=> pin_oe == ($past(cfg.wdata, 2) & IMPL_MASK))
        else $error("pin direction does not follow direction write");

    open_drain_a: assert property (@(posedge clk_sys) disable iff (rst)
        (od & drv_val) != 8'h00 |=> (pin_oe & $past(od & drv_val)) == 8'h00)
        else $error("open-drain pin driven high");
endmodule : ciopb_port
`default_nettype wire

// ### hdl/ciopb_bank.sv
// Configurable I/O port bank: register decode, overrides, macrocells
//
// Summary of operation
// - Port F buffer enabled by mode bit 7
// - Buffer spans all eight port F pins
// - Buffer released unless a select is active
// - Test port shares port E pins
// - Strap pattern on F,G during idle reset
// - Strap stops when reset releases
// - Data port mode takes over F and G
// - Bit n steers pin n; reset zero
// - Registers reached by ordinary host cycles
// - Mode bit: zero host I/O, one address
// - Address out needs enable or direction
// - Direction one output, zero input
// - A,B,C,F: direction OR logic enable
// - Port D keeps only four direction bits
// - Drive bit one gives open drain
// - Input register returns pin levels
// - Output data stored, driven, read back
// - Cell location reads and loads cells
// - Mask bit one blocks cell loading
`timescale 1ns/1ps
`default_nettype none
module ciopb_bank
    import ciopb_pkg::*;
#(
    parameter logic [15:0] STRAP_PATTERN = 16'h0000,
    parameter logic [7:0]  JTAG_PINS     = 8'h0f
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             host_sel,
    input  wire logic [5:0]       host_addr,
    input  wire logic             host_rd,
    input  wire logic             host_wr,
    input  wire logic [7:0]       host_wdata,
    output logic      [7:0]       host_rdata,
    output logic                  host_rvalid,
    input  wire logic             periph_select_first,
    input  wire logic             periph_select_second,
    input  wire logic             data_port_mode,
    input  wire logic             dp_read,
    input  wire logic [15:0]      dp_rdata,
    input  wire logic             jtag_enable,
    input  wire logic             strap_enable,
    input  wire logic             host_reset_in,
    input  wire logic [15:0]      latched_addr,
    input  wire logic             cell_clock_en,
    input  wire logic [15:0]      cell_next,
    output logic      [15:0]      cell_state,
    input  wire logic [6:0][7:0]  pin_in,
    input  wire logic [6:0][7:0]  oe_term,
    output logic      [6:0][7:0]  pin_out,
    output logic      [6:0][7:0]  pin_oe
);
    logic [2:0]      reg_port;
    logic [2:0]      reg_sel;
    logic            reg_wr;
    logic [7:0]      map_mode;
    logic [15:0]     cell_mask;
    logic [15:0]     cell_lanes;
    logic [15:0]     cell_load;
    logic [15:0]     next_cells;
    logic            rst_sync_a;
    logic            reset_sync;
    logic            periph_buffer_enable_bit;
    logic            psel;
    logic            pbuf_wr;
    logic            pbuf_rd;
    logic            strap_drive;
    logic            dp_drive;
    logic [7:0]      next_rdata;
    logic [6:0][7:0] force_en;
    logic [6:0][7:0] force_val;
    logic [6:0][7:0] release_en;
    logic [6:0][7:0] rd_din;
    logic [6:0][7:0] rd_dout;
    logic [6:0][7:0] rd_dir;
    logic [6:0][7:0] rd_drive;
    logic [6:0][7:0] rd_mode;
    logic [6:0][7:0] addr_map;

    if (JTAG_PINS == 8'h00) begin : g_bad
        $error("ciopb_bank: test port must claim at least one pin");
    end

    // ---------------------------------------------------------------
    // Host register decode
    // ---------------------------------------------------------------
    // Offset is {port, select}; port index 7 holds the mode register
    assign reg_port = host_addr[5:3];
    assign reg_sel  = host_addr[2:0];
    assign reg_wr   = host_sel && host_wr;

    // Memory map mode register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            map_mode <= CFG_RESET;
        end else if (reg_wr && reg_port == PORT_MISC && reg_sel == REG_MAP_MODE) begin
            map_mode <= host_wdata;
        end
    end

    // ---------------------------------------------------------------
    // Output macrocells on ports A and B
    // ---------------------------------------------------------------
    // Host load wins over the logic's own clocking in the same cycle
    always_comb begin
        cell_lanes = 16'h0000;
        if (reg_wr && reg_sel == REG_CELLS) begin
            if (reg_port == PORT_A) begin
                cell_lanes = CELL_LANE_A;
            end else if (reg_port == PORT_B) begin
                cell_lanes = CELL_LANE_B;
            end
        end
        cell_load  = cell_lanes & ~cell_mask;
        next_cells = cell_clock_en ? cell_next : cell_state;
        next_cells = (cell_load & {2{host_wdata}}) | (~cell_load & next_cells);
    end

    // Cells and their masks
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cell_state <= CELL_RESET;
            cell_mask  <= CELL_RESET;
        end else begin
            cell_state <= next_cells;
            if (reg_wr && reg_sel == REG_MASK && reg_port == PORT_A) begin
                cell_mask[7:0] <= host_wdata;
            end
            if (reg_wr && reg_sel == REG_MASK && reg_port == PORT_B) begin
                cell_mask[15:8] <= host_wdata;
            end
        end
    end

    // ---------------------------------------------------------------
    // Reset strap and peripheral buffer
    // ---------------------------------------------------------------
    // Host reset is a pin, so it is synchronised before use
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rst_sync_a <= 1'b0;
            reset_sync <= 1'b0;
        end else begin
            rst_sync_a <= host_reset_in;
            reset_sync <= rst_sync_a;
        end
    end

    // The host latches the strap at its reset release, so the pattern
    // must still stand then; the two-stage lag keeps it a little longer
    assign strap_drive = strap_enable && reset_sync && !(host_rd || host_wr);
    assign dp_drive    = data_port_mode && dp_read && !strap_drive;
    assign periph_buffer_enable_bit         = map_mode[PERIPH_EN_BIT];
    assign psel        = periph_select_first || periph_select_second;
    assign pbuf_wr     = periph_buffer_enable_bit && psel && host_wr && !host_sel;
    assign pbuf_rd     = periph_buffer_enable_bit && psel && host_rd && !host_sel;

    // Pin overrides: forces beat releases; strap over data port over buffer write
    always_comb begin
        force_en   = '0;
        force_val  = '0;
        release_en = '0;
        if (jtag_enable) begin
            release_en[PORT_E] = JTAG_PINS;
        end
        if (data_port_mode || periph_buffer_enable_bit) begin
            release_en[PORT_F] = 8'hff;
        end
        if (data_port_mode) begin
            release_en[PORT_G] = 8'hff;
        end
        if (strap_drive) begin
            force_en[PORT_F]  = 8'hff;
            force_en[PORT_G]  = 8'hff;
            force_val[PORT_F] = STRAP_PATTERN[7:0];
            force_val[PORT_G] = STRAP_PATTERN[15:8];
        end else if (dp_drive) begin
            force_en[PORT_F]  = 8'hff;
            force_en[PORT_G]  = 8'hff;
            force_val[PORT_F] = dp_rdata[7:0];
            force_val[PORT_G] = dp_rdata[15:8];
        end else if (pbuf_wr) begin
            force_en[PORT_F]  = 8'hff;
            force_val[PORT_F] = host_wdata;
        end
    end

    // ---------------------------------------------------------------
    // Ports
    // ---------------------------------------------------------------
    // Address lines per port: E and F low byte, G high byte
    always_comb begin
        addr_map         = '0;
        addr_map[PORT_E] = latched_addr[7:0];
        addr_map[PORT_F] = latched_addr[7:0];
        addr_map[PORT_G] = latched_addr[15:8];
    end

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        ciopb_port_if pif ();

        assign pif.wr    = reg_wr && (reg_port == 3'(p));
        assign pif.sel   = reg_sel;
        assign pif.wdata = host_wdata;
        assign rd_din[p]   = pif.din;
        assign rd_dout[p]  = pif.dout;
        assign rd_dir[p]   = pif.dir;
        assign rd_drive[p] = pif.drive;
        assign rd_mode[p]  = pif.mode;

        ciopb_port #(
            .IMPL_MASK (p == int'(PORT_D) ? PORT_D_MASK : 8'hff),
            .HAS_OE    (HAS_OE_TERM[p]),
            .HAS_OD    (HAS_DRIVE[p]),
            .HAS_ADDR  (HAS_ADDR_OUT[p])
        ) u_port (
            .clk_sys    (clk_sys),
            .rst        (rst),
            .cfg        (pif.port),
            .pin_in     (pin_in[p]),
            .oe_term    (oe_term[p]),
            .addr_bits  (addr_map[p]),
            .release_en (release_en[p]),
            .force_en   (force_en[p]),
            .force_val  (force_val[p]),
            .pin_out    (pin_out[p]),
            .pin_oe     (pin_oe[p])
        );
    end

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    // Unmapped selects read as zero
    always_comb begin
        next_rdata = 8'h00;
        if (pbuf_rd) begin
            next_rdata = rd_din[PORT_F];
        end else if (reg_port == PORT_MISC) begin
            next_rdata = (reg_sel == REG_MAP_MODE) ? map_mode : 8'h00;
        end else begin
            case (reg_sel)
                REG_INPUT:  next_rdata = rd_din[reg_port];
                REG_OUTPUT: next_rdata = rd_dout[reg_port];
                REG_DIR:    next_rdata = rd_dir[reg_port];
                REG_DRIVE:  next_rdata = rd_drive[reg_port];
                REG_MODE:   next_rdata = rd_mode[reg_port];
                REG_CELLS: begin
                    if (reg_port == PORT_A) begin
                        next_rdata = cell_state[7:0];
                    end else if (reg_port == PORT_B) begin
                        next_rdata = cell_state[15:8];
                    end
                end
                REG_MASK: begin
                    if (reg_port == PORT_A) begin
                        next_rdata = cell_mask[7:0];
                    end else if (reg_port == PORT_B) begin
                        next_rdata = cell_mask[15:8];
                    end
                end
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // Answer one edge after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            host_rdata  <= 8'h00;
            host_rvalid <= 1'b0;
        end else begin
            host_rdata  <= next_rdata;
            host_rvalid <= (host_sel && host_rd) || pbuf_rd;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    periph_tristate_a: assert property (
        periph_buffer_enable_bit && !psel && !strap_drive && !dp_drive |=> pin_oe[PORT_F] == 8'h00)
        else $error("peripheral buffer driven without select");

    periph_write_a: assert property (
        pbuf_wr && !strap_drive && !dp_drive
        |=> pin_oe[PORT_F] == 8'hff && pin_out[PORT_F] == $past(host_wdata))
        else $error("peripheral write not driven to port F");

    periph_read_a: assert property (
        pbuf_rd |=> host_rvalid && host_rdata == $past(rd_din[PORT_F]))
        else $error("peripheral read did not return port F");

    periph_gate_a: assert property (
        !periph_buffer_enable_bit && !data_port_mode && rd_dir[PORT_F] == 8'h00 && rd_mode[PORT_F] == 8'h00
        && oe_term[PORT_F] == 8'h00 && !strap_drive
        |=> pin_oe[PORT_F] == 8'h00)
        else $error("port F driven with buffer mode off");

    strap_drive_a: assert property (
        strap_drive |=> pin_oe[PORT_F] == 8'hff && pin_out[PORT_F] == STRAP_PATTERN[7:0])
        else $error("strap pattern missing on port F");

    strap_end_a: assert property (
        !strap_drive && data_port_mode && !dp_read
        |=> pin_oe[PORT_F] == 8'h00 && pin_oe[PORT_G] == 8'h00)
        else $error("data port still driven after strap");

    cell_mask_a: assert property (
        cell_lanes != 16'h0000 && !cell_clock_en
        |=> ((cell_state ^ $past(cell_state)) & $past(cell_mask)) == 16'h0000)
        else $error("masked cell was loaded");

    cell_load_a: assert property (
        reg_wr && reg_sel == REG_CELLS && reg_port == PORT_A
        |=> ((cell_state[7:0] ^ $past(host_wdata)) & ~$past(cell_mask[7:0])) == 8'h00)
        else $error("cell write not loaded");

    input_read_a: assert property (
        host_sel && host_rd && reg_port == PORT_C && reg_sel == REG_INPUT
        |=> host_rvalid && host_rdata == $past(rd_din[PORT_C]))
        else $error("input read wrong");

    strap_seen_c: cover property (strap_drive ##1 !strap_drive);
    periph_rd_c: cover property (pbuf_rd ##1 host_rvalid);
    periph_wr_c: cover property (pbuf_wr);
    masked_wr_c: cover property (cell_lanes != 16'h0000 && (cell_lanes & cell_mask) != 16'h0000);
endmodule : ciopb_bank
`default_nettype wire

// ### testbench/ciopb_host_model.sv
// Host model: drives its reset pin and samples the data lines
`timescale 1ns/1ps
`default_nettype none
module ciopb_host_model
    import ciopb_pkg::*;
(
    input  wire logic            hold_reset,
    input  wire logic [6:0][7:0] pin_out,
    input  wire logic [6:0][7:0] pin_oe,
    output logic                 host_reset_in,
    output logic      [15:0]     strap_seen
);
    logic [15:0] bus;
    // Released data lines float high through pull-ups
    assign bus = {pin_out[PORT_G] | ~pin_oe[PORT_G], pin_out[PORT_F] | ~pin_oe[PORT_F]};
    assign host_reset_in = hold_reset;
    // Levels latched as reset releases, while straps still drive
    always @(negedge hold_reset) begin
        strap_seen <= bus;
    end
endmodule : ciopb_host_model
`default_nettype wire

// ### testbench/ciopb_bank_tb_top.sv
// Self-checking bench for the I/O port bank
`timescale 1ns/1ps
`default_nettype none
module ciopb_bank_tb_top
    import ciopb_pkg::*;
;
    // ------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------
    localparam logic [15:0] STRAP = 16'h3c96;
    localparam logic [7:0]  JTAG  = 8'h0f;
    logic            clk_sys = 1'b0, rst = 1'b1, host_sel = 1'b0, host_rd = 1'b0, host_wr = 1'b0;
    logic            sel_first = 1'b0, sel_second = 1'b0, dpm = 1'b0, dp_read = 1'b0;
    logic            strap = 1'b0, hold_rst = 1'b0, cell_en = 1'b0, jtag = 1'b0, rvalid, host_reset_in;
    logic [5:0]      addr = '0;
    logic [7:0]      wdata = '0, rdata;
    logic [15:0]     dp_rdata = '0, laddr = '0, cell_next = '0, cell_state, strap_seen;
    logic [6:0][7:0] pin_in = '0, oe_term = '0, pin_out, pin_oe;
    int              err_total = 0, n_compared = 0;

    always #50 clk_sys = ~clk_sys;

    ciopb_bank #(.STRAP_PATTERN(STRAP), .JTAG_PINS(JTAG)) ciopb_bank_inst (.clk_sys(clk_sys), .rst(rst),
        .host_sel(host_sel), .host_addr(addr), .host_rd(host_rd), .host_wr(host_wr),
        .host_wdata(wdata), .host_rdata(rdata), .host_rvalid(rvalid),
        .periph_select_first(sel_first), .periph_select_second(sel_second),
        .data_port_mode(dpm), .dp_read(dp_read), .dp_rdata(dp_rdata), .jtag_enable(jtag),
        .strap_enable(strap), .host_reset_in(host_reset_in), .latched_addr(laddr),
        .cell_clock_en(cell_en), .cell_next(cell_next), .cell_state(cell_state),
        .pin_in(pin_in), .oe_term(oe_term), .pin_out(pin_out), .pin_oe(pin_oe));

    ciopb_host_model ciopb_host_model_inst (.hold_reset(hold_rst), .pin_out(pin_out),
        .pin_oe(pin_oe), .host_reset_in(host_reset_in), .strap_seen(strap_seen));

    // ------------------------------------------
    // Access and compare tasks
    // ------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Strobe drops for a full cycle so calls never retrigger in one step
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        host_sel = 1'b1;
        host_wr = 1'b1;
        @(negedge clk_sys);
        host_sel = 1'b0;
        host_wr = 1'b0;
        @(negedge clk_sys);
    endtask : wr

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
        addr = a;
        host_sel = 1'b1;
        host_rd = 1'b1;
        @(negedge clk_sys);
        host_sel = 1'b0;
        host_rd = 1'b0;
        // Answer stands for one cycle only, so look before it goes
        chk((rvalid === 1'b1) ? rdata : ~exp, exp);
        @(negedge clk_sys);
    endtask : rd_chk

    task automatic periph_wr(input logic [7:0] d, input logic [7:0] exp_oe);
        wdata = d;
        sel_first = 1'b1;
        host_wr = 1'b1;
        @(negedge clk_sys);
        chk(pin_oe[PORT_F], exp_oe);
        chk(pin_out[PORT_F] & exp_oe, d & exp_oe);
        host_wr = 1'b0;
        sel_first = 1'b0;
        @(negedge clk_sys);
        chk(pin_oe[PORT_F], 8'h00);
    endtask : periph_wr

    task automatic tally_and_finish;
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // Watchdog: the tests need well under 1000 cycles
    initial begin
        #1000000;
        err_total++;
        tally_and_finish();
    end

    // ------------------------------------------
    // Tests
    // ------------------------------------------
    initial begin
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        rd_chk({PORT_A, REG_DIR}, CFG_RESET);
        rd_chk({PORT_G, REG_MODE}, CFG_RESET);
        rd_chk({PORT_B, REG_MASK}, CFG_RESET);
        rd_chk({PORT_C, REG_DRIVE}, 8'h00);
        rd_chk({PORT_MISC, 3'h5}, 8'h00);
        wr({PORT_A, REG_OUTPUT}, 8'h5a);
        wr({PORT_A, REG_DIR}, 8'h07);
        chk(pin_oe[PORT_A], 8'h07);
        chk(pin_out[PORT_A] & 8'h07, 8'h02);
        rd_chk({PORT_A, REG_OUTPUT}, 8'h5a);
        rd_chk({PORT_A, REG_DIR}, 8'h07);
        oe_term[PORT_A] = 8'h30;
        oe_term[PORT_E] = 8'hff;
        repeat (2) @(negedge clk_sys);
        chk(pin_oe[PORT_A], 8'h37);
        chk(pin_oe[PORT_E], 8'h00);
        wr({PORT_A, REG_DRIVE}, 8'hff);
        chk(pin_oe[PORT_A], 8'h25);
        wr({PORT_D, REG_DIR}, 8'hff);
        rd_chk({PORT_D, REG_DIR}, 8'h0f);
        chk(pin_oe[PORT_D], 8'h0f);
        pin_in[PORT_C] = 8'hc3;
        pin_in[PORT_F] = 8'h3c;
        repeat (3) @(negedge clk_sys);
        rd_chk({PORT_C, REG_INPUT}, 8'hc3);
        // Address out on port E follows the latched low byte
        laddr = 16'h12e4;
        wr({PORT_E, REG_MODE}, 8'hff);
        chk(pin_out[PORT_E], 8'he4);
        chk(pin_oe[PORT_E], 8'hff);
        wr({PORT_E, REG_MODE}, 8'h00);
        chk(pin_oe[PORT_E], 8'h00);
        // Test port claims its port E pins whatever the direction says
        jtag = 1'b1;
        wr({PORT_E, REG_DIR}, 8'hff);
        chk(pin_oe[PORT_E], ~JTAG);
        jtag = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk(pin_oe[PORT_E], 8'hff);
        // Masked cells keep their state on a host load
        wr({PORT_A, REG_MASK}, 8'h0f);
        wr({PORT_A, REG_CELLS}, 8'hff);
        rd_chk({PORT_A, REG_CELLS}, 8'hf0);
        cell_next = 16'hffff;
        cell_en = 1'b1;
        @(negedge clk_sys);
        cell_en = 1'b0;
        chk(cell_state[7:0], 8'hff);
        rd_chk({PORT_B, REG_CELLS}, 8'hff);
        // Peripheral buffer off, then on
        periph_wr(8'h5a, 8'h00);
        wr({PORT_MISC, REG_MAP_MODE}, 8'h80);
        periph_wr(8'h5a, 8'hff);
        sel_second = 1'b1;
        host_rd = 1'b1;
        @(negedge clk_sys);
        chk(pin_oe[PORT_F], 8'h00);
        chk((rvalid === 1'b1) ? rdata : 8'h00, 8'h3c);
        host_rd = 1'b0;
        sel_second = 1'b0;
        @(negedge clk_sys);
        // Data port read drives F low byte and G high byte
        dpm = 1'b1;
        dp_read = 1'b1;
        dp_rdata = 16'ha55a;
        repeat (2) @(negedge clk_sys);
        chk(pin_out[PORT_F], 8'h5a);
        chk(pin_out[PORT_G] & pin_oe[PORT_G], 8'ha5);
        // Data port without a read leaves both ports released
        dp_read = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk(pin_oe[PORT_F], 8'h00);
        chk(pin_oe[PORT_G], 8'h00);
        dpm = 1'b0;
        // Strap pattern only while host reset is held
        strap = 1'b1;
        hold_rst = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk(pin_out[PORT_F] & pin_oe[PORT_F], STRAP[7:0]);
        chk(pin_out[PORT_G] & pin_oe[PORT_G], STRAP[15:8]);
        hold_rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk(pin_oe[PORT_F], 8'h00);
        chk(pin_oe[PORT_G], 8'h00);
        chk(strap_seen[7:0], STRAP[7:0]);
        chk(strap_seen[15:8], STRAP[15:8]);
        tally_and_finish();
    end
endmodule : ciopb_bank_tb_top
`default_nettype wire
